// ===== logic/defect_csc_top.sv
// defect_csc_top: defect entry staging, vertical line defect table and correction,
// colour conversion matrix and position bias, behind a plain 16-bit register port
// assumes: pixel stream synchronous to REF_CLK with row/column counts from upstream
//
// Overview of operation
// - row coordinate of a defect held in bits 11-0 of first entry register
// - column coordinate of a defect held in bits 11-0 of second entry register
// - on-line level shifted left and subtracted from pixels on the defect row
// - above-line level shifted and subtracted from rows above the defect
// - below-line level shifted and subtracted from rows below the defect
// - conversion matrix applied only while enable bit is 1, reset 0
// - coefficients packed two per register, row-major, even column in low byte
// - vertical bias in upper byte shifts row position for correction
// - horizontal bias in lower byte shifts column position for correction
// - skip-upper bit set leaves pixels above defect uncorrected
`timescale 1ns/10ps
module defect_csc_top (
  input  wire logic                                    REF_CLK,
  input  wire logic                                    RST_N,
  input  wire logic [dtc_pkg::ADDR_W-1:0]              REG_ADDR,
  input  wire logic [dtc_pkg::REG_W-1:0]               REG_WDATA,
  input  wire logic                                    REG_WR,
  input  wire logic                                    REG_RD,
  output logic [dtc_pkg::REG_W-1:0]                    REG_RDATA,
  input  wire logic                                    PIX_VALID,
  output logic                                         PIX_READY,
  input  wire logic [dtc_pkg::POS_W-1:0]               PIX_ROW,
  input  wire logic [dtc_pkg::POS_W-1:0]               PIX_COL,
  input  wire logic [dtc_pkg::CH_N*dtc_pkg::PIX_W-1:0] PIX_DATA,
  output logic                                         OUT_VALID,
  input  wire logic                                    OUT_READY,
  output logic [dtc_pkg::CH_N*dtc_pkg::PIX_W-1:0]      OUT_DATA
);
  localparam int unsigned PW = dtc_pkg::PIX_W;
  localparam int unsigned DW = dtc_pkg::CH_N * PW;
  localparam int unsigned NC = dtc_pkg::CH_N * dtc_pkg::CH_N;

  typedef enum logic [1:0] {TBL_IDLE, TBL_WRITE, TBL_DONE} tbl_state_e;

  // software-visible fields
  logic [dtc_pkg::POS_W-1:0]   defect_row_coord_r;
  logic [dtc_pkg::POS_W-1:0]   defect_col_coord_r;
  logic [dtc_pkg::LVL_W-1:0]   level_on_line_r;
  logic [dtc_pkg::LVL_W-1:0]   level_above_line_r;
  logic [dtc_pkg::LVL_W-1:0]   level_below_line_r;
  logic                        color_convert_on_r;
  logic [dtc_pkg::COEF_W-1:0]  coef_r [NC];
  logic [dtc_pkg::BIAS_W-1:0]  vertical_position_bias_r;
  logic [dtc_pkg::BIAS_W-1:0]  horizontal_position_bias_r;
  logic [dtc_pkg::SHIFT_W-1:0] defect_level_shift_r;
  logic                        skip_upper_pixels_r;
  logic                        line_corr_en_r;
  logic                        defect_table_write_go_r;
  logic                        addr_reset_r;
  logic [dtc_pkg::TIDX_W-1:0]  tbl_idx_r;
  logic [dtc_pkg::TIDX_W:0]    tbl_used_r;
  tbl_state_e                  tbl_state_r;
  logic [dtc_pkg::REG_W-1:0]   rdata_nxt;

  // defect table: one entry per vertical line defect
  logic [dtc_pkg::POS_W-1:0]   tbl_row_r [dtc_pkg::TABLE_N];
  logic [dtc_pkg::POS_W-1:0]   tbl_col_r [dtc_pkg::TABLE_N];
  logic [dtc_pkg::LVL_W-1:0]   tbl_on_r  [dtc_pkg::TABLE_N];
  logic [dtc_pkg::LVL_W-1:0]   tbl_abv_r [dtc_pkg::TABLE_N];
  logic [dtc_pkg::LVL_W-1:0]   tbl_blw_r [dtc_pkg::TABLE_N];

  logic                        wr_hit;
  logic [dtc_pkg::TIDX_W-1:0]  coef_pair;
  assign wr_hit    = REG_WR;
  assign coef_pair = dtc_pkg::TIDX_W'(REG_ADDR - dtc_pkg::OFS_COEF0);

  // staging field writes; unmapped writes are dropped
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      defect_row_coord_r <= '0;
      defect_col_coord_r <= '0;
      level_on_line_r    <= '0;
      level_above_line_r <= '0;
      level_below_line_r <= '0;
    end
    else if (wr_hit)
    begin
      unique case (REG_ADDR)
        dtc_pkg::OFS_ROW:     defect_row_coord_r <= REG_WDATA[dtc_pkg::POS_W-1:0];
        dtc_pkg::OFS_COL:     defect_col_coord_r <= REG_WDATA[dtc_pkg::POS_W-1:0];
        dtc_pkg::OFS_LVL_ON:  level_on_line_r    <= REG_WDATA[dtc_pkg::LVL_W-1:0];
        dtc_pkg::OFS_LVL_ABV: level_above_line_r <= REG_WDATA[dtc_pkg::LVL_W-1:0];
        dtc_pkg::OFS_LVL_BLW: level_below_line_r <= REG_WDATA[dtc_pkg::LVL_W-1:0];
        default: ;
      endcase
    end
  end

  // conversion enable, bias and correction control
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      color_convert_on_r         <= 1'b0;
      vertical_position_bias_r   <= '0;
      horizontal_position_bias_r <= '0;
      defect_level_shift_r       <= '0;
      skip_upper_pixels_r        <= 1'b0;
      line_corr_en_r             <= 1'b0;
    end
    else if (wr_hit)
    begin
      if (REG_ADDR == dtc_pkg::OFS_CSC_CTRL)
        color_convert_on_r <= REG_WDATA[dtc_pkg::BIT_EN];
      if (REG_ADDR == dtc_pkg::OFS_BIAS)
      begin
        vertical_position_bias_r   <= REG_WDATA[dtc_pkg::REG_W-1 -: dtc_pkg::BIAS_W];
        horizontal_position_bias_r <= REG_WDATA[dtc_pkg::BIAS_W-1:0];
      end
      if (REG_ADDR == dtc_pkg::OFS_DFC_CTRL)
      begin
        // a forbidden shift of 7 is clamped so the datapath never overflows
        defect_level_shift_r <= (REG_WDATA[dtc_pkg::BIT_SHIFT_LO +: dtc_pkg::SHIFT_W] > dtc_pkg::SHIFT_MAX)
                                ? dtc_pkg::SHIFT_MAX
                                : REG_WDATA[dtc_pkg::BIT_SHIFT_LO +: dtc_pkg::SHIFT_W];
        skip_upper_pixels_r  <= REG_WDATA[dtc_pkg::BIT_SKIPUP];
        line_corr_en_r       <= REG_WDATA[dtc_pkg::BIT_VDFC_EN];
      end
    end
  end

  // coefficient pairs: even column low byte, odd column high byte, row-major
  for (genvar k = 0; k < NC / 2; k++)
  begin : g_coef
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
      if (!RST_N)
      begin
        coef_r[2*k]   <= '0;
        coef_r[2*k+1] <= '0;
      end
      else if (wr_hit && REG_ADDR >= dtc_pkg::OFS_COEF0 && REG_ADDR <= dtc_pkg::OFS_COEF7
               && coef_pair == dtc_pkg::TIDX_W'(k))
      begin
        coef_r[2*k]   <= REG_WDATA[dtc_pkg::COEF_W-1:0];
        coef_r[2*k+1] <= REG_WDATA[dtc_pkg::REG_W-1 -: dtc_pkg::COEF_W];
      end
    end
  end

  // table load sequencer: go bit self-clears one cycle after the entry is stored
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tbl_state_r             <= TBL_IDLE;
      defect_table_write_go_r <= 1'b0;
      addr_reset_r            <= 1'b0;
      tbl_idx_r               <= '0;
      tbl_used_r              <= '0;
    end
    else
    begin
      unique case (tbl_state_r)
        TBL_IDLE:
        begin
          if (wr_hit && REG_ADDR == dtc_pkg::OFS_MEM_CTRL)
          begin
            addr_reset_r <= REG_WDATA[dtc_pkg::BIT_ARST];
            if (REG_WDATA[dtc_pkg::BIT_WR_GO])
            begin
              defect_table_write_go_r <= 1'b1;
              tbl_state_r             <= TBL_WRITE;
              if (REG_WDATA[dtc_pkg::BIT_ARST])
                tbl_idx_r <= '0;
            end
          end
        end
        TBL_WRITE:
          tbl_state_r <= TBL_DONE;
        TBL_DONE:
        begin
          defect_table_write_go_r <= 1'b0;
          addr_reset_r            <= 1'b0;
          if (tbl_used_r <= (dtc_pkg::TIDX_W+1)'(tbl_idx_r))
            tbl_used_r <= (dtc_pkg::TIDX_W+1)'(tbl_idx_r) + 1'b1;
          tbl_idx_r   <= tbl_idx_r + 1'b1;
          tbl_state_r <= TBL_IDLE;
        end
      endcase
    end
  end

  // entry copy into the table, all five fields together
  always_ff @(posedge REF_CLK)
  begin
    if (tbl_state_r == TBL_WRITE)
    begin
      tbl_row_r[tbl_idx_r] <= defect_row_coord_r;
      tbl_col_r[tbl_idx_r] <= defect_col_coord_r;
      tbl_on_r[tbl_idx_r]  <= level_on_line_r;
      tbl_abv_r[tbl_idx_r] <= level_above_line_r;
      tbl_blw_r[tbl_idx_r] <= level_below_line_r;
    end
  end

  // read mux; registered so data stands the cycle after the strobe
  always_comb
  begin
    rdata_nxt = dtc_pkg::RD_UNMAPPED;
    unique case (REG_ADDR)
      dtc_pkg::OFS_ROW:      rdata_nxt = dtc_pkg::REG_W'(defect_row_coord_r);
      dtc_pkg::OFS_COL:      rdata_nxt = dtc_pkg::REG_W'(defect_col_coord_r);
      dtc_pkg::OFS_LVL_ON:   rdata_nxt = dtc_pkg::REG_W'(level_on_line_r);
      dtc_pkg::OFS_LVL_ABV:  rdata_nxt = dtc_pkg::REG_W'(level_above_line_r);
      dtc_pkg::OFS_LVL_BLW:  rdata_nxt = dtc_pkg::REG_W'(level_below_line_r);
      dtc_pkg::OFS_CSC_CTRL: rdata_nxt = dtc_pkg::REG_W'(color_convert_on_r);
      dtc_pkg::OFS_BIAS:     rdata_nxt = {vertical_position_bias_r, horizontal_position_bias_r};
      dtc_pkg::OFS_DFC_CTRL: rdata_nxt = dtc_pkg::REG_W'({defect_level_shift_r, skip_upper_pixels_r,
                                          2'h0, line_corr_en_r, 4'h0});
      dtc_pkg::OFS_MEM_CTRL: rdata_nxt = dtc_pkg::REG_W'({tbl_state_r != TBL_IDLE, addr_reset_r,
                                          1'b0, defect_table_write_go_r});
      default:
        if (REG_ADDR >= dtc_pkg::OFS_COEF0 && REG_ADDR <= dtc_pkg::OFS_COEF7)
          rdata_nxt = {coef_r[2*coef_pair+1], coef_r[2*coef_pair]};
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      REG_RDATA <= dtc_pkg::RST_VAL;
    else if (REG_RD)
      REG_RDATA <= rdata_nxt;
  end

  // defect correction: biased position compared against every table entry
  logic [dtc_pkg::POS_W-1:0] row_pos;
  logic [dtc_pkg::POS_W-1:0] col_pos;
  logic [dtc_pkg::LVL_W-1:0] sub_lvl;
  logic                      sub_hit;
  logic [DW-1:0]             corr_data;
  assign row_pos = PIX_ROW + dtc_pkg::POS_W'(vertical_position_bias_r);
  assign col_pos = PIX_COL + dtc_pkg::POS_W'(horizontal_position_bias_r);

  // last matching entry wins; entries not yet loaded never match
  always_comb
  begin
    sub_lvl = '0;
    sub_hit = 1'b0;
    for (int i = 0; i < dtc_pkg::TABLE_N; i++)
    begin
      if (line_corr_en_r && (dtc_pkg::TIDX_W+1)'(i) < tbl_used_r && col_pos == tbl_col_r[i])
      begin
        if (row_pos == tbl_row_r[i])
        begin
          sub_lvl = tbl_on_r[i];
          sub_hit = 1'b1;
        end
        else if (row_pos < tbl_row_r[i] && !skip_upper_pixels_r)
        begin
          sub_lvl = tbl_abv_r[i];
          sub_hit = 1'b1;
        end
        else if (row_pos > tbl_row_r[i])
        begin
          sub_lvl = tbl_blw_r[i];
          sub_hit = 1'b1;
        end
      end
    end
  end

  // subtract shifted level per channel, clamping at zero
  for (genvar c = 0; c < dtc_pkg::CH_N; c++)
  begin : g_sub
    logic [PW-1:0] amount;
    assign amount = PW'({6'h00, sub_lvl} << defect_level_shift_r);
    assign corr_data[c*PW +: PW] = (!sub_hit) ? PIX_DATA[c*PW +: PW]
                                 : (PIX_DATA[c*PW +: PW] > amount) ? PIX_DATA[c*PW +: PW] - amount
                                 : '0;
  end

  // one register stage feeding the fifo; holds while the fifo is full
  logic          stage_valid_r;
  logic          fifo_ready;
  logic          advance;
  logic [DW-1:0] csc_out;
  assign advance   = !stage_valid_r || fifo_ready;
  assign PIX_READY = advance;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      stage_valid_r <= 1'b0;
    else if (advance)
      stage_valid_r <= PIX_VALID;
  end

  logic [NC*dtc_pkg::COEF_W-1:0] coef_flat;
  for (genvar j = 0; j < NC; j++)
  begin : g_flat
    assign coef_flat[j*dtc_pkg::COEF_W +: dtc_pkg::COEF_W] = coef_r[j];
  end

  csc_core u_csc (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .enable  (color_convert_on_r),
    .advance (advance),
    .coefs   (coef_flat),
    .pix_in  (corr_data),
    .pix_out (csc_out)
  );

  pix_fifo #(.WIDTH(DW), .DEPTH(dtc_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .in_valid  (stage_valid_r),
    .in_ready  (fifo_ready),
    .in_data   (csc_out),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_DATA)
  );

  // checks
  sequence s_go_written;
    REG_WR && REG_ADDR == dtc_pkg::OFS_MEM_CTRL && REG_WDATA[dtc_pkg::BIT_WR_GO] && tbl_state_r == TBL_IDLE;
  endsequence
  a_go_selfclear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    s_go_written |=> defect_table_write_go_r [*2] ##1 !defect_table_write_go_r) else $error("go not cleared");
  a_csc_reset_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> !color_convert_on_r) else $error("csc enabled after reset");
  a_shift_range: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    defect_level_shift_r <= dtc_pkg::SHIFT_MAX) else $error("shift out of range");
  a_row_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == dtc_pkg::OFS_ROW |=> defect_row_coord_r == $past(REG_WDATA[11:0])) else $error("row");
  a_col_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == dtc_pkg::OFS_COL |=> defect_col_coord_r == $past(REG_WDATA[11:0])) else $error("col");
  a_bias_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == dtc_pkg::OFS_BIAS |=> vertical_position_bias_r == $past(REG_WDATA[15:8])
    && horizontal_position_bias_r == $past(REG_WDATA[7:0])) else $error("bias");
  a_coef_pack: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    REG_WR && REG_ADDR == dtc_pkg::OFS_COEF0 |=> coef_r[1] == $past(REG_WDATA[15:8])
    && coef_r[0] == $past(REG_WDATA[7:0])) else $error("coef pack");
  a_skip_upper: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    skip_upper_pixels_r && line_corr_en_r && tbl_used_r == 5'h01 && col_pos == tbl_col_r[0]
    && row_pos < tbl_row_r[0] |-> corr_data == PIX_DATA) else $error("upper pixels corrected");
  a_sub_none: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !line_corr_en_r |-> corr_data == PIX_DATA) else $error("correction while off");
  a_pass_through: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    advance && !color_convert_on_r |=> csc_out == $past(corr_data)) else $error("pass");
endmodule // defect_csc_top

// ===== logic/dtc_pkg.sv
// package: register map, field layout and datapath constants for the defect / colour block
// assumes: 16-bit register port, 125 MHz clock, 4-channel 14-bit pixel words
package dtc_pkg;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned PIX_W    = 14;
  localparam int unsigned CH_N     = 4;
  localparam int unsigned COEF_W   = 8;
  localparam int unsigned COEF_FRAC = 5;
  localparam int unsigned POS_W    = 12;
  localparam int unsigned LVL_W    = 8;
  localparam int unsigned BIAS_W   = 8;
  localparam int unsigned SHIFT_W  = 3;
  localparam int unsigned TABLE_N  = 16;
  localparam int unsigned TIDX_W   = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  // register offsets (word addresses on the plain port)
  localparam logic [7:0] OFS_ROW      = 8'h00;
  localparam logic [7:0] OFS_COL      = 8'h01;
  localparam logic [7:0] OFS_LVL_ON   = 8'h02;
  localparam logic [7:0] OFS_LVL_ABV  = 8'h03;
  localparam logic [7:0] OFS_LVL_BLW  = 8'h04;
  localparam logic [7:0] OFS_CSC_CTRL = 8'h05;
  localparam logic [7:0] OFS_COEF0    = 8'h06;
  localparam logic [7:0] OFS_COEF7    = 8'h0D;
  localparam logic [7:0] OFS_BIAS     = 8'h0E;
  localparam logic [7:0] OFS_DFC_CTRL = 8'h0F;
  localparam logic [7:0] OFS_MEM_CTRL = 8'h10;
  // field positions
  localparam int unsigned BIT_EN       = 0;
  localparam int unsigned BIT_SKIPUP   = 7;
  localparam int unsigned BIT_SHIFT_LO = 8;
  localparam int unsigned BIT_VDFC_EN  = 4;
  localparam int unsigned BIT_WR_GO    = 0;
  localparam int unsigned BIT_ARST     = 2;
  localparam int unsigned BIT_BUSY     = 3;
  localparam logic [15:0] RST_VAL      = 16'h0000;
  localparam logic [15:0] RD_UNMAPPED  = 16'h0000;
  localparam logic [2:0]  SHIFT_MAX    = 3'h6;
endpackage

// ===== logic/pix_fifo.sv
// pix_fifo: synchronous first-word-fall-through FIFO with valid/ready on both sides
// assumes: one clock, active-low asynchronous reset
`timescale 1ns/10ps
module pix_fifo #(
  parameter int unsigned WIDTH = 56,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rptr_r];

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wptr_r] <= in_data;
  end

  // pointers wrap naturally because depth is a power of two
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end
    else
    begin
      if (push)
        wptr_r <= wptr_r + 1'b1;
      if (pop)
        rptr_r <= rptr_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_r == (AW+1)'(DEPTH)) |-> !in_ready) else $error("fifo full but ready");
endmodule // pix_fifo

// ===== logic/csc_core.sv
// csc_core: registered 4x4 colour matrix with pass-through when disabled
// assumes: coefficients signed with five fractional bits, pixels unsigned
`timescale 1ns/10ps
module csc_core (
  input  wire logic                                       clk,
  input  wire logic                                       rst_n,
  input  wire logic                                       enable,
  input  wire logic                                       advance,
  input  wire logic [dtc_pkg::CH_N*dtc_pkg::CH_N*dtc_pkg::COEF_W-1:0] coefs,
  input  wire logic [dtc_pkg::CH_N*dtc_pkg::PIX_W-1:0]    pix_in,
  output logic [dtc_pkg::CH_N*dtc_pkg::PIX_W-1:0]         pix_out
);
  localparam int unsigned PW  = dtc_pkg::PIX_W;
  localparam int unsigned CW  = dtc_pkg::COEF_W;
  localparam int unsigned ACC = PW + CW + 3;
  logic [PW-1:0] out_nxt [dtc_pkg::CH_N];

  // one output channel per row: sum of four products, then saturate
  for (genvar r = 0; r < dtc_pkg::CH_N; r++)
  begin : g_row
    always_comb
    begin
      logic signed [ACC-1:0] acc;
      logic signed [ACC-1:0] scaled;
      acc = '0;
      scaled = '0;
      for (int c = 0; c < dtc_pkg::CH_N; c++)
        acc = acc + ACC'($signed(coefs[(r*dtc_pkg::CH_N+c)*CW +: CW])
                * $signed({1'b0, pix_in[c*PW +: PW]}));
      scaled = acc >>> dtc_pkg::COEF_FRAC;
      if (!enable)
        out_nxt[r] = pix_in[r*PW +: PW];
      else if (scaled < 0)
        out_nxt[r] = '0;
      else if (scaled > ACC'({PW{1'b1}}))
        out_nxt[r] = '1;
      else
        out_nxt[r] = scaled[PW-1:0];
    end

    // same register stage in both modes so latency never changes
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        pix_out[r*PW +: PW] <= '0;
      else if (advance)
        pix_out[r*PW +: PW] <= out_nxt[r];
    end
  end
endmodule // csc_core

// ===== verification/pix_sink.sv
// pix_sink: output partner, stalls ready one cycle in three, or fully on hold
// assumes: one clock, ready changes just after a rising edge
`timescale 1ns/10ps
module pix_sink (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hold,
  output logic      ready
);
  logic [1:0] cnt_r;
  // periodic stall keeps the fifo partly full under traffic
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt_r <= 2'h0;
      ready <= 1'b0;
    end
    else
    begin
      cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
      ready <= !hold && (cnt_r != 2'h0);
    end
endmodule // pix_sink

// ===== verification/defect_csc_top_test.sv
// defect_csc_top_test: register and random pixel traffic with self-checks
// assumes: design sources and pix_sink compiled first
`timescale 1ns/10ps
module defect_csc_top_test;
  localparam int DR = 40;
  localparam int DC = 20;
  localparam int VB = 3;
  localparam int HB = 5;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [15:0] rdata;
  logic        pv = 1'b0;
  logic        pr;
  logic [11:0] prow = 12'h000;
  logic [11:0] pcol = 12'h000;
  logic [55:0] pdata = 56'h0;
  logic        ov;
  logic        ordy;
  logic        hold = 1'b0;
  logic [55:0] od;
  logic [15:0] seed = 16'h5272;
  logic [55:0] expq[$];
  logic        cen = 1'b0;
  logic        csc = 1'b0;
  logic        skip = 1'b0;
  logic [2:0]  sh = 3'h0;
  logic [7:0]  lv[3];
  int          errors = 0;
  int          num_checks = 0;
  defect_csc_top uut (.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s),
    .REG_RD(rd_s), .REG_RDATA(rdata), .PIX_VALID(pv), .PIX_READY(pr), .PIX_ROW(prow), .PIX_COL(pcol),
    .PIX_DATA(pdata), .OUT_VALID(ov), .OUT_READY(ordy), .OUT_DATA(od));
  pix_sink sink (.clk(clk), .rst_n(rst_n), .hold(hold), .ready(ordy));
  always #4 clk = ~clk;
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] msk(input int a);
    return (a < 2) ? 16'h0FFF : (a < 5) ? 16'h00FF : (a == 5) ? 16'h0001 : 16'hFFFF;
  endfunction
  // correction first, then the pair-swapping matrix when conversion is on
  function automatic logic [55:0] exp_px(input logic [55:0] d, input logic [11:0] r, input logic [11:0] c);
    logic [13:0] ch[4];
    logic [7:0]  lvl;
    logic [13:0] sub;
    lvl = (r + VB == DR) ? lv[0] : (r + VB < DR) ? (skip ? 8'h00 : lv[1]) : lv[2];
    if (!cen || c + HB != DC) lvl = 8'h00;
    sub = 14'(lvl) << sh;
    for (int i = 0; i < 4; i++) ch[i] = (d[i*14 +: 14] > sub) ? d[i*14 +: 14] - sub : 14'h0000;
    return csc ? {ch[2], ch[3], ch[0], ch[1]} : {ch[3], ch[2], ch[1], ch[0]};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int a, input logic [15:0] d);
    @(posedge clk);
    addr <= 8'(a);
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input int a, output logic [15:0] v);
    @(posedge clk);
    addr <= 8'(a);
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // hold the pixel until ready is seen before an edge, or give up after bound cycles
  task automatic push(input logic [55:0] d, input logic [11:0] r, c, input int bound, output logic ok);
    ok = 1'b0;
    @(posedge clk);
    pv <= 1'b1;
    pdata <= d;
    prow <= r;
    pcol <= c;
    for (int i = 0; i < bound && !ok; i++)
    begin
      @(negedge clk);
      ok = (pr === 1'b1);
      @(posedge clk);
    end
    if (ok) expq.push_back(exp_px(d, r, c));
    pv <= 1'b0;
  endtask
  task automatic send(input int n, input int bound, output int acc);
    logic [55:0] d;
    logic        ok;
    acc = 0;
    repeat (n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        seed = nxt(seed);
        d[i*14 +: 14] = seed[13:0];
      end
      push(d, 12'(DR - VB - 1) + 12'(seed % 3), 12'(DC - HB) - 12'(seed[4]), bound, ok);
      acc += int'(ok);
    end
  endtask
  task automatic drain;
    for (int i = 0; i < 400 && expq.size() > 0; i++) @(posedge clk);
    if (expq.size() > 0)
    begin
      errors++;
      tally_and_finish();
    end
  endtask
  // every accepted pixel leaves in order with its worked-out value
  always @(posedge clk)
    if (ov === 1'b1 && ordy === 1'b1) chk(od, expq.pop_front());
  initial
  begin
    logic [15:0] v;
    int          n;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 16; a++)
    begin
      rd(a, v);
      chk(56'(v), 56'(dtc_pkg::RST_VAL));
    end
    for (int a = 0; a <= 14; a++)
    begin
      seed = nxt(seed);
      wr(a, seed & msk(a));
      rd(a, v);
      chk(56'(v), 56'(seed & msk(a)));
    end
    wr(8'h20, 16'hFFFF);
    rd(8'h20, v);
    chk(56'(v), 56'(dtc_pkg::RD_UNMAPPED));
    wr(dtc_pkg::OFS_CSC_CTRL, 16'h0000);
    wr(dtc_pkg::OFS_BIAS, 16'(VB * 256 + HB));
    wr(dtc_pkg::OFS_ROW, 16'(DR));
    wr(dtc_pkg::OFS_COL, 16'(DC));
    for (int i = 0; i < 3; i++)
    begin
      seed = nxt(seed);
      lv[i] = seed[7:0];
      wr(2 + i, 16'(lv[i]));
    end
    sh = 3'(seed % 7);
    skip = seed[11];
    wr(dtc_pkg::OFS_MEM_CTRL, 16'h0005);
    n = 0;
    do
    begin
      rd(dtc_pkg::OFS_MEM_CTRL, v);
      n++;
    end
    while ((v & 16'h0009) != 16'h0000 && n < 20);
    chk(56'(v & 16'h0009), 56'h0);
    cen = 1'b1;
    wr(dtc_pkg::OFS_DFC_CTRL, {5'h00, sh, skip, 7'h10});
    send(60, 50, n);
    drain();
    skip = !skip;
    wr(dtc_pkg::OFS_DFC_CTRL, {5'h00, sh, skip, 7'h10});
    send(30, 50, n);
    drain();
    cen = 1'b0;
    wr(dtc_pkg::OFS_DFC_CTRL, 16'h0000);
    for (int k = 0; k < 8; k++)
      wr(6 + k, (k == 0 || k == 5) ? 16'h2000 : (k == 2 || k == 7) ? 16'h0020 : 16'h0000);
    csc = 1'b1;
    wr(dtc_pkg::OFS_CSC_CTRL, 16'h0001);
    send(40, 50, n);
    drain();
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    send(12, 3, n);
    chk(56'(n), 56'(dtc_pkg::FIFO_DEPTH + 1));
    hold <= 1'b0;
    drain();
    tally_and_finish();
  end
endmodule // defect_csc_top_test
